/* inc/adcsl_lane_if.sv */
/*
  Carrier between the converter core and the lane transmitter.
  Assumes the core drives every signal; the transmitter resynchronises all of them but the word.
*/
`timescale 1ns/1ps
interface adcsl_lane_if;
  import adcsl_pkg::*;
  logic [RES_BITS-1:0] word;
  logic                enable;
  logic                dual_pin;
  logic                pat_pin;
  logic                pat_sw;
  modport core (output word, enable, dual_pin, pat_pin, pat_sw);
  modport lane (input word, enable, dual_pin, pat_pin, pat_sw);
endinterface

/* inc/adcsl_pkg.sv */
/*
  Constants, register map and state type shared by the serial-lane converter core
  and its link-side lane transmitter.
  Assumes a 50 MHz system clock; the link shift clock comes from the capture logic.
*/
package adcsl_pkg;
  // Result shape and conversion pacing
  localparam int RES_BITS  = 18;
  localparam int STEP_BITS = 9;
  localparam int STEPS     = RES_BITS / STEP_BITS;
  localparam int STEP_W    = (STEPS > 1) ? $clog2(STEPS) : 1;
  localparam int IDX_W     = 5;
  localparam logic [IDX_W-1:0] LAST_SINGLE = 5'h11;
  localparam logic [IDX_W-1:0] LAST_DUAL   = 5'h08;
  // Timing
  localparam int CLK_PERIOD_PS = 20000;
  localparam int T_FIRSTCLK_NS = 80;
  localparam int FIRSTCLK_CYC  = (T_FIRSTCLK_NS * 1000) / CLK_PERIOD_PS;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RESULT = 8'h08;
  localparam logic [7:0] REG_COUNT  = 8'h0c;
  // Field positions
  localparam int CTRL_PD_BIT   = 0;
  localparam int CTRL_PAT_BIT  = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ON_BIT   = 1;
  localparam int STAT_DUAL_BIT = 2;
  localparam int STAT_PAT_BIT  = 3;
  // Reset values and fixed pattern
  localparam logic [1:0]          CTRL_RST     = 2'h0;
  localparam logic [RES_BITS-1:0] RESULT_RST   = 18'h00000;
  localparam logic [15:0]         COUNT_RST    = 16'h0000;
  localparam logic [RES_BITS-1:0] TEST_PATTERN = 18'h2a5c3;
  // Converter phases
  typedef enum logic [1:0] {ST_OFF, ST_ACQ, ST_CONV} adcsl_state_t;
endpackage

/* verif/adcsl_rx_model.sv */
/*
  Capture-side model: makes the shift clock in bursts and gathers lane bits
  on the falling edge of the echoed strobe.
  Assumes the caller starts a frame only after the convert edge has passed.
*/
`timescale 1ns/1ps
module adcsl_rx_model
  import adcsl_pkg::*;
(
  // Link pins
  output logic      shift_clk_o,
  input  wire logic echoed_data_strobe_i,
  input  wire logic lane_a_out_i,
  input  wire logic lane_b_out_i,
  // Lane mode the receiver expects
  input  wire logic dual_i
);
  logic [RES_BITS-1:0] cap_q = '0;

  // Clock stands still outside frames
  initial shift_clk_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Shift lane bits in on the falling strobe, one or two per pulse
  always @(negedge echoed_data_strobe_i) begin
    if (dual_i) begin
      cap_q <= {cap_q[RES_BITS-3:0], lane_a_out_i, lane_b_out_i};
    end else begin
      cap_q <= {cap_q[RES_BITS-2:0], lane_a_out_i};
    end
  end

  // Burst of shift clock pulses at a 48 ns period
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      #24 shift_clk_o = 1'b1;
      #24 shift_clk_o = 1'b0;
    end
    #2;
  endtask

  // One whole frame, MSB first; offs is the offset-binary reading
  task automatic frame(output logic [RES_BITS-1:0] word, output logic [RES_BITS-1:0] offs);
    #80;
    pulses(dual_i ? STEP_BITS : RES_BITS);
    word = cap_q;
    offs = {~cap_q[RES_BITS-1], cap_q[RES_BITS-2:0]};
  endtask
endmodule

/* verif/test_adcsl_top.sv */
/*
  Self-checking bench: a table of conversions in both lane modes, then register,
  pattern, power-down and mid-run reset cases.
  Assumes adcsl_rx_model supplies the shift clock and gathers the frames.
*/
`timescale 1ns/1ps
module test_adcsl_top
  import adcsl_pkg::*;
;
  typedef struct packed {logic [RES_BITS-1:0] lvl; logic dual;} adcsl_row_t;

  logic                clk_i = 1'b0;
  logic                rst_i = 1'b1;
  logic                wb_cyc_i = 1'b0;
  logic                wb_stb_i = 1'b0;
  logic                wb_we_i = 1'b0;
  logic [7:0]          wb_adr_i = 8'h00;
  logic [3:0]          wb_sel_i = 4'h0;
  logic [31:0]         wb_dat_i = 32'h0;
  logic [31:0]         wb_dat_o;
  logic                wb_ack_o;
  logic                convert_start_i = 1'b0;
  logic                power_down_n_i = 1'b1;
  logic                pattern_force_i = 1'b0;
  logic                dual_lane_select_i = 1'b0;
  logic [RES_BITS-1:0] analog_level_i = 18'h00000;
  logic                sclk;
  logic                lane_a_out_o, lane_a_oe_o, lane_b_out_o, lane_b_oe_o;
  logic                echoed_data_strobe_o;
  int                  fails = 0;
  int                  compares = 0;
  int                  cycles = 0;
  adcsl_row_t          rows [6] = '{'{18'h00000, 1'b0}, '{18'h3ffff, 1'b0},
    '{18'h20000, 1'b0}, '{18'h1ffff, 1'b1}, '{18'h2a5c3, 1'b1}, '{18'h15a3c, 1'b1}};
  logic [7:0]          zero_adr [4] = '{REG_CTRL, REG_RESULT, REG_COUNT, 8'h10};

  adcsl_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .convert_start_i(convert_start_i),
    .power_down_n_i(power_down_n_i), .pattern_force_i(pattern_force_i),
    .dual_lane_select_i(dual_lane_select_i), .analog_level_i(analog_level_i),
    .shift_clk_i(sclk), .lane_a_out_o(lane_a_out_o), .lane_a_oe_o(lane_a_oe_o),
    .lane_b_out_o(lane_b_out_o), .lane_b_oe_o(lane_b_oe_o),
    .echoed_data_strobe_o(echoed_data_strobe_o));

  adcsl_rx_model u_rx (.shift_clk_o(sclk), .echoed_data_strobe_i(echoed_data_strobe_o),
    .lane_a_out_i(lane_a_out_o), .lane_b_out_i(lane_b_out_o), .dual_i(dual_lane_select_i));

  ////////////////////////////////////////////////////////////////////////////////
  // System clock, 20 ns
  always #10 clk_i = ~clk_i;

  // Cut a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end

  // Strobe follows the shift clock while the lanes drive
  always @(sclk) begin
    #3;
    if (lane_a_oe_o === 1'b1) check(echoed_data_strobe_o, sclk);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison and closing report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Classic Wishbone single cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                    output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    wb_sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (n >= 50) check(1'b0, 1'b1);
  endtask

  // Find frame alignment with the forced pattern, then flush it
  task automatic align();
    logic [RES_BITS-1:0] w, o;
    int tries;
    tries = 0;
    @(posedge clk_i);
    pattern_force_i <= 1'b1;
    u_rx.pulses(RES_BITS);
    u_rx.frame(w, o);
    while (w !== TEST_PATTERN && tries < 20) begin
      u_rx.pulses(1);
      u_rx.frame(w, o);
      tries++;
    end
    check(w, TEST_PATTERN);
    @(posedge clk_i);
    pattern_force_i <= 1'b0;
    u_rx.pulses(dual_lane_select_i ? STEP_BITS : RES_BITS);
  endtask

  // Set the level, pulse convert for 40 ns, then read one frame
  task automatic convert(input logic [RES_BITS-1:0] lvl, output logic [RES_BITS-1:0] w,
                         output logic [RES_BITS-1:0] o);
    @(posedge clk_i);
    analog_level_i <= lvl;
    repeat (3) @(posedge clk_i);
    convert_start_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    convert_start_i <= 1'b0;
    u_rx.frame(w, o);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [RES_BITS-1:0] w, o;
    fork
      u_rx.pulses(3);
    join_none
    repeat (5) @(posedge clk_i);
    check(wb_ack_o, 1'b0);
    rst_i <= 1'b0;
    foreach (zero_adr[i]) begin
      wb(1'b0, zero_adr[i], 32'h0, d);
      check(d, 32'h0);
    end
    wb(1'b0, REG_STATUS, 32'h0, d);
    check(d, 32'h2);
    align();
    // Conversion table, realigning on each lane mode change
    foreach (rows[i]) begin
      if (rows[i].dual !== dual_lane_select_i) begin
        @(posedge clk_i);
        dual_lane_select_i <= rows[i].dual;
        align();
      end
      check(lane_b_oe_o, rows[i].dual);
      if (rows[i].dual === 1'b0) check(lane_b_out_o, 1'b0);
      convert(rows[i].lvl, w, o);
      check(w, {~rows[i].lvl[17], rows[i].lvl[16:0]});
      check(o, rows[i].lvl);
      wb(1'b0, REG_RESULT, 32'h0, d);
      check(d, {14'h0, ~rows[i].lvl[17], rows[i].lvl[16:0]});
    end
    wb(1'b0, REG_COUNT, 32'h0, d);
    check(d, 32'h6);
    wb(1'b1, REG_COUNT, 32'h0, d);
    wb(1'b1, REG_RESULT, 32'h3ffff, d);
    wb(1'b0, REG_RESULT, 32'h0, d);
    check(d, 32'h35a3c);
    wb(1'b0, REG_COUNT, 32'h0, d);
    check(d, 32'h0);
    // Soft pattern through the control register, in dual mode
    wb(1'b1, REG_CTRL, 32'h2, d);
    u_rx.pulses(STEP_BITS);
    u_rx.frame(w, o);
    check(w, TEST_PATTERN);
    wb(1'b0, REG_STATUS, 32'h0, d);
    check(d[STAT_PAT_BIT], 1'b1);
    wb(1'b1, REG_CTRL, 32'h0, d);
    // Soft power-down and back
    wb(1'b1, REG_CTRL, 32'h1, d);
    wb(1'b0, REG_STATUS, 32'h0, d);
    check(d[STAT_ON_BIT], 1'b0);
    wb(1'b1, REG_CTRL, 32'h0, d);
    wb(1'b0, REG_STATUS, 32'h0, d);
    check(d[STAT_ON_BIT], 1'b1);
    // Pin power-down: lanes off, convert ignored
    @(posedge clk_i);
    power_down_n_i <= 1'b0;
    u_rx.pulses(4);
    check(lane_a_oe_o, 1'b0);
    check(lane_b_oe_o, 1'b0);
    convert(18'h0f0f0, w, o);
    wb(1'b0, REG_COUNT, 32'h0, d);
    check(d, 32'h0);
    wb(1'b0, REG_STATUS, 32'h0, d);
    check(d[STAT_ON_BIT], 1'b0);
    @(posedge clk_i);
    power_down_n_i <= 1'b1;
    // Power back on: conversions count again
    convert(18'h0f0f0, w, o);
    wb(1'b0, REG_COUNT, 32'h0, d);
    check(d, 32'h1);
    // Mid-run reset returns the registers to their reset values
    wb(1'b1, REG_CTRL, 32'h2, d);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    check(wb_ack_o, 1'b0);
    check(wb_dat_o, 32'h0);
    rst_i <= 1'b0;
    foreach (zero_adr[i]) begin
      wb(1'b0, zero_adr[i], 32'h0, d);
      check(d, 32'h0);
    end
    stop_test();
  end
endmodule

/* verilog/adcsl_lane_tx.sv */
/*
  Lane transmitter on the shift clock: picks result bits MSB first and echoes the clock.
  Assumes the result word holds still through a frame and the receiver counts pulses.
*/
`timescale 1ns/1ps
module adcsl_lane_tx
  import adcsl_pkg::*;
(
  // Link clock and system reset
  input  wire logic   lclk_i,
  input  wire logic   rst_i,
  // From the core
  adcsl_lane_if.lane  lif,
  // Lane pins
  output logic        lane_a_out_o,
  output logic        lane_a_oe_o,
  output logic        lane_b_out_o,
  output logic        lane_b_oe_o,
  output logic        echoed_data_strobe_o
);
  logic [1:0]          rst_s_q;
  logic [1:0]          en_s_q;
  logic [1:0]          dual_s_q;
  logic [1:0]          patp_s_q;
  logic [1:0]          pats_s_q;
  logic                lrst;
  logic                en;
  logic                dual;
  logic [IDX_W-1:0]    idx_q;
  logic [IDX_W-1:0]    last;
  logic [IDX_W:0]      sh;
  logic [RES_BITS-1:0] src;
  logic [RES_BITS-1:0] shifted;
  logic                a_q;
  logic                b_q;
  logic                a_oe_q;
  logic                b_oe_q;
  logic                strobe_en_q;

  //////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers into the link domain
  always_ff @(posedge lclk_i) begin
    rst_s_q  <= {rst_s_q[0], rst_i};
    en_s_q   <= {en_s_q[0], lif.enable};
    dual_s_q <= {dual_s_q[0], lif.dual_pin};
    patp_s_q <= {patp_s_q[0], lif.pat_pin};
    pats_s_q <= {pats_s_q[0], lif.pat_sw};
  end

  assign lrst = rst_s_q[1];
  assign en   = en_s_q[1];
  assign dual = dual_s_q[1];

  // Source word and MSB-first bit selection
  assign src     = (patp_s_q[1] | pats_s_q[1]) ? TEST_PATTERN : lif.word;
  assign last    = dual ? LAST_DUAL : LAST_SINGLE;
  assign sh      = dual ? {idx_q, 1'b0} : {1'b0, idx_q};
  assign shifted = src << sh;

  //////////////////////////////////////////////////////////////////////////////
  // Pulse counter; each shift clock moves the frame on, wraps at frame end
  always_ff @(posedge lclk_i) begin
    if (lrst || !en) begin
      idx_q <= '0;
    end else if (idx_q == last) begin
      idx_q <= '0;
    end else begin
      idx_q <= idx_q + 5'h01;
    end
  end

  // Lane data and driver enables
  always_ff @(posedge lclk_i) begin
    if (lrst || !en) begin
      a_q    <= 1'b0;
      b_q    <= 1'b0;
      a_oe_q <= 1'b0;
      b_oe_q <= 1'b0;
    end else begin
      a_q    <= shifted[RES_BITS-1];
      b_q    <= dual ? shifted[RES_BITS-2] : 1'b0;
      a_oe_q <= 1'b1;
      b_oe_q <= dual;
    end
  end

  // Strobe gate, changed only while the clock is low so the echo has no glitch
  always_ff @(negedge lclk_i) begin
    strobe_en_q <= en && !lrst;
  end

  assign echoed_data_strobe_o = lclk_i & strobe_en_q;
  assign lane_a_out_o = a_q;
  assign lane_b_out_o = b_q;
  assign lane_a_oe_o  = a_oe_q;
  assign lane_b_oe_o  = b_oe_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks on the link domain
  default clocking @(posedge lclk_i); endclocking
  default disable iff (lrst);

  property p_dual_lanes;
    en && dual |=> b_oe_q && (b_q == $past(shifted[RES_BITS-2]));
  endproperty
  a_dual_lanes: assert property (p_dual_lanes) else $error("lane b not driven in dual mode");

  property p_single_lane;
    !dual |=> !b_oe_q && (a_q == ($past(en) && $past(shifted[RES_BITS-1])));
  endproperty
  a_single_lane: assert property (p_single_lane) else $error("lane b active in single mode");

  property p_pattern;
    en && !dual && (patp_s_q[1] || pats_s_q[1]) && (idx_q == 5'h00) |=>
      a_q == TEST_PATTERN[RES_BITS-1];
  endproperty
  a_pattern: assert property (p_pattern) else $error("test pattern msb missing");

  property p_frame_wrap;
    en && (idx_q == last) |=> idx_q == 5'h00;
  endproperty
  a_frame_wrap: assert property (p_frame_wrap) else $error("frame counter did not wrap");
endmodule

/* verilog/adcsl_top.sv */
/*
  Converter core with Wishbone control: acquisition, successive approximation
  and result hand-off to the lane transmitter running on the shift clock.
  Assumes the analog level arrives as an 18-bit offset-binary stand-in on a pin,
  the convert edges keep their minimum spacing, and a classic Wishbone master.
*/
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module adcsl_top
  import adcsl_pkg::*;
(
  // System clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Converter pins
  input  wire logic                convert_start_i,
  input  wire logic                power_down_n_i,
  input  wire logic                pattern_force_i,
  input  wire logic                dual_lane_select_i,
  input  wire logic [RES_BITS-1:0] analog_level_i,
  // Serial link
  input  wire logic                shift_clk_i,
  output logic                     lane_a_out_o,
  output logic                     lane_a_oe_o,
  output logic                     lane_b_out_o,
  output logic                     lane_b_oe_o,
  output logic                     echoed_data_strobe_o
);
  localparam int LAT_MAX = FIRSTCLK_CYC - 2;
  localparam logic [RES_BITS-1:0] MSB_MASK = 18'h20000;

  adcsl_lane_if lif ();

  logic [2:0]          cnv_s_q;
  logic [1:0]          pd_s_q;
  logic [1:0]          dual_s_q;
  logic [1:0]          pat_s_q;
  logic [RES_BITS-1:0] ana_s1_q;
  logic [RES_BITS-1:0] ana_s2_q;
  logic                cnv_rise;
  logic                powered;
  adcsl_state_t        state_q;
  logic [RES_BITS-1:0] hold_q;
  logic [RES_BITS-1:0] code_q;
  logic [RES_BITS-1:0] code_d;
  logic [STEP_W-1:0]   step_q;
  logic                conv_done;
  logic [RES_BITS-1:0] result_q;
  logic [15:0]         count_q;
  logic [1:0]          ctrl_q;
  logic                en_q;
  logic                ack_q;
  logic [31:0]         rdat_q;
  logic                req;
  logic                wr_now;
  logic                count_clr;

  //////////////////////////////////////////////////////////////////////////////
  // Successive approximation over one group of bits, MSB of the group first
  function automatic logic [RES_BITS-1:0] sar_step(
    input logic [RES_BITS-1:0] code,
    input logic [RES_BITS-1:0] held,
    input logic [STEP_W-1:0]   step
  );
    logic [RES_BITS-1:0] c;
    logic [RES_BITS-1:0] trial;
    int                  b;
    c = code;
    for (int i = 0; i < STEP_BITS; i++) begin
      b     = RES_BITS - 1 - (int'(step) * STEP_BITS) - i;
      trial = c | (18'h00001 << b);
      if (held >= trial) begin
        c = trial;
      end
    end
    return c;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for the pins; a third convert flop finds the edge
  always_ff @(posedge clk_i) begin
    cnv_s_q  <= {cnv_s_q[1:0], convert_start_i};
    pd_s_q   <= {pd_s_q[0], power_down_n_i};
    dual_s_q <= {dual_s_q[0], dual_lane_select_i};
    pat_s_q  <= {pat_s_q[0], pattern_force_i};
    ana_s1_q <= analog_level_i;
    ana_s2_q <= ana_s1_q;
  end

  assign cnv_rise = cnv_s_q[1] & ~cnv_s_q[2];
  assign powered  = pd_s_q[1] & ~ctrl_q[CTRL_PD_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Phase sequencer: off, acquisition, conversion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_OFF;
    end else if (!powered) begin
      state_q <= ST_OFF;
    end else begin
      unique case (state_q)
        ST_OFF: begin
          state_q <= ST_ACQ;
        end
        ST_ACQ: begin
          if (cnv_rise) begin
            state_q <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (conv_done) begin
            state_q <= ST_ACQ;
          end
        end
      endcase
    end
  end

  // Sample hold: the sample is taken from the input only on the convert edge in acquisition, then held
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_q <= RESULT_RST;
    end else if (state_q == ST_ACQ && powered && cnv_rise) begin
      hold_q <= ana_s2_q;
    end
  end

  // Approximation register and step counter
  assign code_d    = sar_step(code_q, hold_q, step_q);
  assign conv_done = (state_q == ST_CONV) && (step_q == STEP_W'(STEPS - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_q <= RESULT_RST;
      step_q <= '0;
    end else if (state_q == ST_ACQ) begin
      code_q <= RESULT_RST;
      step_q <= '0;
    end else if (state_q == ST_CONV) begin
      code_q <= code_d;
      step_q <= step_q + STEP_W'(1);
    end
  end

  // Result load: offset code with MSB inverted gives two's complement
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_q <= RESULT_RST;
    end else if (conv_done) begin
      result_q <= code_d ^ MSB_MASK;
    end
  end

  // Conversion counter; a software clear in the cycle a conversion finishes leaves a count of one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= COUNT_RST;
    end else if (conv_done) begin
      count_q <= count_clr ? 16'h0001 : count_q + 16'h0001;
    end else if (count_clr) begin
      count_q <= COUNT_RST;
    end
  end

  // Lane enable follows power state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
    end else begin
      en_q <= powered;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the request, writes land on the ack edge
  assign req       = wb_cyc_i & wb_stb_i;
  assign wr_now    = req & wb_we_i & ack_q;
  assign count_clr = wr_now && (wb_adr_i == REG_COUNT) && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Control register: soft power-down and soft pattern force
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_now && (wb_adr_i == REG_CTRL) && wb_sel_i[0]) begin
      ctrl_q <= wb_dat_i[1:0];
    end
  end

  // Read data captured when the request is first seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h00000000;
    end else if (req && !ack_q) begin
      unique case (wb_adr_i)
        REG_CTRL: begin
          rdat_q <= {30'h00000000, ctrl_q};
        end
        REG_STATUS: begin
          rdat_q                <= 32'h00000000;
          rdat_q[STAT_BUSY_BIT] <= (state_q == ST_CONV);
          rdat_q[STAT_ON_BIT]   <= powered;
          rdat_q[STAT_DUAL_BIT] <= dual_s_q[1];
          rdat_q[STAT_PAT_BIT]  <= pat_s_q[1] | ctrl_q[CTRL_PAT_BIT];
        end
        REG_RESULT: begin
          rdat_q <= {14'h0000, result_q};
        end
        REG_COUNT: begin
          rdat_q <= {16'h0000, count_q};
        end
        default: begin
          rdat_q <= 32'h00000000;
        end
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  //////////////////////////////////////////////////////////////////////////////
  // Hand-off to the link domain; the word is held still between conversions
  assign lif.word     = result_q;
  assign lif.enable   = en_q;
  assign lif.dual_pin = dual_lane_select_i;
  assign lif.pat_pin  = pattern_force_i;
  assign lif.pat_sw   = ctrl_q[CTRL_PAT_BIT];

  adcsl_lane_tx u_lane (
    .lclk_i               (shift_clk_i),
    .rst_i                (rst_i),
    .lif                  (lif),
    .lane_a_out_o         (lane_a_out_o),
    .lane_a_oe_o          (lane_a_oe_o),
    .lane_b_out_o         (lane_b_out_o),
    .lane_b_oe_o          (lane_b_oe_o),
    .echoed_data_strobe_o (echoed_data_strobe_o)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks on the system domain
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_start;
    (state_q == ST_ACQ) && powered && cnv_rise;
  endsequence

  sequence s_conv_run;
    (state_q == ST_CONV)[*2] ##1 (state_q == ST_ACQ);
  endsequence

  property p_start_hold;
    s_start |=> (state_q == ST_CONV) && (hold_q == $past(ana_s2_q));
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("convert edge did not hold");

  property p_phases;
    disable iff (rst_i || !powered)
    s_start |=> s_conv_run;
  endproperty
  a_phases: assert property (p_phases) else $error("phase order broken");

  property p_sar_exact;
    conv_done |=> code_q == $past(hold_q);
  endproperty
  a_sar_exact: assert property (p_sar_exact) else $error("approximation not exact");

  property p_result_load;
    conv_done |=> (result_q == (code_q ^ MSB_MASK)) &&
      (count_q == ($past(count_clr) ? 16'h0001 : $past(count_q) + 16'h0001));
  endproperty
  a_result_load: assert property (p_result_load) else $error("result not loaded");

  property p_twos;
    conv_done |=> $signed(result_q) == ($signed({1'b0, hold_q}) - 19'sh20000);
  endproperty
  a_twos: assert property (p_twos) else $error("result not two's complement");

  property p_latency;
    disable iff (rst_i || !powered)
    s_start |-> ##[1:LAT_MAX] conv_done;
  endproperty
  a_latency: assert property (p_latency) else $error("conversion too slow");

  property p_power_off;
    !powered |=> (state_q == ST_OFF) && !en_q;
  endproperty
  a_power_off: assert property (p_power_off) else $error("power-down not honoured");

  property p_pd_pin;
    !pd_s_q[1] ##1 !pd_s_q[1] |-> !en_q && (state_q == ST_OFF);
  endproperty
  a_pd_pin: assert property (p_pd_pin) else $error("power-down pin ignored");
endmodule
